// ---- fqu_pkg.sv ----
// Purpose: Shared constants for the flash query and unprotect host controller
// Assumes: 125 MHz ref_clk; flash pins reached through pad logic outside
// Notes: Query table offsets are word addresses; byte mode keeps A-1 low
// Notes on behaviour
// - Unprotect only while reset pin at high voltage
// - Query entry: 98h to 55h/AAh from array-read
// - Word-mode query reads keep A7 upward zero
// - Reset command ends query, back to array-read; the flash model returns to identification mode if query was entered from it
package fqu_pkg;
	localparam int unsigned CLK_PERIOD_PS = 8000;
	localparam int unsigned WR_PULSE_NS = 35;
	localparam int unsigned RD_ACCESS_NS = 70;
	localparam int unsigned POWERUP_US = 50;
	localparam int unsigned WR_PULSE_CYC = (WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RD_ACCESS_CYC = (RD_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SYNC_STAGES = 2;
	localparam int unsigned RD_WAIT_CYC = RD_ACCESS_CYC + SYNC_STAGES;
	localparam int unsigned POWERUP_CYC_DEF = (POWERUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int IDX_W = 7;
	localparam int TMR_W = 8;
	localparam logic [ADDR_W-1:0] QUERY_ADDR = 21'h000055;
	localparam logic [DATA_W-1:0] QUERY_CMD = 16'h0098;
	localparam logic [DATA_W-1:0] RESET_CMD = 16'h00F0;
	localparam logic [ADDR_W-1:0] RESET_ADDR = 21'h000000;
	localparam logic [7:0] BYTE_MASK = 8'hFF;
	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_ENTER = 2'h1,
		OP_EXIT = 2'h2
	} fqu_op_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_STROBE = 3'b011,
		ST_HOLD = 3'b010
	} fqu_state_e;
endpackage

// ---- fqu_cycle_timer.sv ----
// Purpose: Down counter that times flash strobe widths
// Assumes: start is a one-cycle pulse while idle
// Notes: done pulses in the cycle the count reaches one
`timescale 1ns/1ps
`default_nettype none
module fqu_cycle_timer #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic [W-1:0] load,
	output logic done
);
	logic [W-1:0] count;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			count <= '0;
		end else if (start) begin
			count <= load;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign done = (count == {{(W-1){1'b0}}, 1'b1});
endmodule // fqu_cycle_timer
`default_nettype wire

// ---- fqu_query_host.sv ----
// Purpose: Host side bus controller for the flash query and unprotect modes
// Assumes: One command at a time; flash data returns on flashDqIn
// Notes: All pin outputs are registered; flashDqIn is synchronised
`timescale 1ns/1ps
`default_nettype none
module fqu_query_host #(
	parameter int unsigned POWERUP_CYCLES = fqu_pkg::POWERUP_CYC_DEF
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic opValid,
	input wire fqu_pkg::fqu_op_e opCode,
	input wire logic [fqu_pkg::IDX_W-1:0] opIndex,
	input wire logic byteMode,
	input wire logic tempUnprotect,
	output logic opReady,
	output logic opRefused,
	output logic rdValid,
	output logic [fqu_pkg::DATA_W-1:0] rdData,
	output logic inQuery,
	output logic unprotectActive,
	output logic flashCeN,
	output logic flashWeN,
	output logic flashOeN,
	output logic flashByteN,
	output logic [fqu_pkg::ADDR_W-1:0] flashAddr,
	output logic flashAddrM1,
	output logic [fqu_pkg::DATA_W-1:0] flashDqOut,
	output logic flashDqOe,
	input wire logic [fqu_pkg::DATA_W-1:0] flashDqIn,
	output logic flashResetVid
);
	import fqu_pkg::*;

	localparam int PW_W = $clog2(POWERUP_CYCLES + 1);

	fqu_state_e state;
	logic isWrite;
	logic isExit;
	logic pwrDone;
	logic [PW_W-1:0] pwrCnt;
	logic tmrStart;
	logic [TMR_W-1:0] tmrLoad;
	logic tmrDone;
	logic [DATA_W-1:0] dqMeta;
	logic [DATA_W-1:0] dqSync;
	logic take;

	assign take = opValid && opReady;

	fqu_cycle_timer #(
		.W(TMR_W)
	) u_timer (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.start(tmrStart),
		.load(tmrLoad),
		.done(tmrDone)
	);

	// ----------------------------------------
	// Power-up hold-off
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pwrCnt <= '0;
			pwrDone <= 1'b0;
		end else if (!pwrDone) begin
			pwrCnt <= pwrCnt + 1'b1;
			pwrDone <= (pwrCnt == PW_W'(POWERUP_CYCLES - 1));
		end
	end

	// ----------------------------------------
	// Data input synchroniser
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			dqMeta <= '0;
			dqSync <= '0;
		end else begin
			dqMeta <= flashDqIn;
			dqSync <= dqMeta;
		end
	end

	// ----------------------------------------
	// High voltage on reset pin
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			flashResetVid <= 1'b0;
			unprotectActive <= 1'b0;
		end else begin
			flashResetVid <= tempUnprotect && pwrDone;
			unprotectActive <= tempUnprotect && pwrDone;
		end
	end

	// ----------------------------------------
	// Bus cycle sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state <= ST_IDLE;
			opReady <= 1'b0;
			opRefused <= 1'b0;
			isWrite <= 1'b0;
			isExit <= 1'b0;
			tmrStart <= 1'b0;
			tmrLoad <= '0;
			flashCeN <= 1'b1;
			flashWeN <= 1'b1;
			flashOeN <= 1'b1;
			flashByteN <= 1'b1;
			flashAddr <= '0;
			flashAddrM1 <= 1'b0;
			flashDqOut <= '0;
			flashDqOe <= 1'b0;
		end else begin
			tmrStart <= 1'b0;
			opRefused <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					opReady <= pwrDone && !take;
					flashByteN <= !byteMode;
					if (take) begin
						flashAddrM1 <= 1'b0;
						state <= ST_SETUP;
						case (opCode)
							OP_READ: begin
								isWrite <= 1'b0;
								flashAddr <= {{(ADDR_W-IDX_W){1'b0}}, opIndex};
							end
							OP_ENTER: begin
								isWrite <= 1'b1;
								isExit <= 1'b0;
								flashAddr <= QUERY_ADDR;
								flashDqOut <= QUERY_CMD;
								if (inQuery) begin
									opRefused <= 1'b1;
									state <= ST_IDLE;
									opReady <= 1'b1;
								end
							end
							OP_EXIT: begin
								isWrite <= 1'b1;
								isExit <= 1'b1;
								flashAddr <= RESET_ADDR;
								flashDqOut <= RESET_CMD;
							end
							default: begin
								opRefused <= 1'b1;
								state <= ST_IDLE;
								opReady <= 1'b1;
							end
						endcase
					end
				end
				ST_SETUP: begin
					// Address settles before the strobe falls
					flashCeN <= 1'b0;
					flashDqOe <= isWrite;
					tmrStart <= 1'b1;
					tmrLoad <= isWrite ? TMR_W'(WR_PULSE_CYC) : TMR_W'(RD_WAIT_CYC);
					flashWeN <= !isWrite;
					flashOeN <= isWrite;
					state <= ST_STROBE;
				end
				ST_STROBE: begin
					if (tmrDone) begin
						flashWeN <= 1'b1;
						flashOeN <= 1'b1;
						state <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					// Write strobe rises before chip select releases
					flashCeN <= 1'b1;
					flashDqOe <= 1'b0;
					opReady <= 1'b1;
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Query mode tracking and read return
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			inQuery <= 1'b0;
		end else if (state == ST_HOLD && isWrite) begin
			inQuery <= !isExit;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rdValid <= 1'b0;
			rdData <= '0;
		end else begin
			rdValid <= (state == ST_STROBE) && tmrDone && !isWrite;
			if ((state == ST_STROBE) && tmrDone && !isWrite) begin
				rdData <= !flashByteN ? {8'h00, dqSync[7:0] & BYTE_MASK} : dqSync;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_powerup_no_write: assert property (!pwrDone |-> flashWeN && flashCeN)
		else $error("write strobe active during power-up");
	a_high_addr_zero: assert property (!flashOeN && flashByteN |-> flashAddr[ADDR_W-1:IDX_W] == '0)
		else $error("high address bits set on query read");
	a_query_cmd_value: assert property ($rose(flashWeN) && !isExit && isWrite
		|-> flashDqOut == QUERY_CMD && flashAddr == QUERY_ADDR && !flashCeN)
		else $error("query entry write carries wrong address or data");
	a_exit_leaves_query: assert property ($rose(flashWeN) && isExit |-> ##2 !inQuery)
		else $error("query mode not left after reset command");
	a_vid_follows_req: assert property (pwrDone && tempUnprotect |=> flashResetVid)
		else $error("high voltage not applied while unprotect requested");
	a_vid_drops: assert property (!tempUnprotect |=> !flashResetVid && !unprotectActive)
		else $error("high voltage held after unprotect request dropped");
	a_strobe_width: assert property ($fell(flashWeN) |-> !flashWeN [*6] ##1 flashWeN)
		else $error("write pulse width wrong");
	a_byte_read_low: assert property (rdValid && !flashByteN |-> rdData[15:8] == 8'h00)
		else $error("byte mode read returned upper byte");
endmodule // fqu_query_host
`default_nettype wire

// ---- fqu_flash_model.sv ----
// Purpose: Behavioural flash device answering the query host controller
// Assumes: Pins come straight from the host; no wire delays
// Notes: Undriven data lines show the inverse of the last driven value
`timescale 1ns/1ps
`default_nettype none
module fqu_flash_model #(
	parameter int PWR_NS = 100
) (
	input wire logic flashCeN,
	input wire logic flashWeN,
	input wire logic flashOeN,
	input wire logic flashByteN,
	input wire logic [20:0] flashAddr,
	input wire logic flashAddrM1,
	input wire logic [15:0] flashDqOut,
	input wire logic flashResetVid,
	output logic [15:0] dq
);
	logic query = 1'b0;
	logic ident = 1'b0;
	logic unprot;
	logic drive;
	logic [21:0] cmdAddr = 22'h000000;
	logic [15:0] rdv;
	logic [15:0] lastQ = 16'h0000;
	int badAddr = 0;
	function automatic logic [15:0] cfiWord(input logic [6:0] i);
		case (i)
			7'h10: return 16'h0051;
			7'h11: return 16'h0052;
			7'h12: return 16'h0059;
			7'h13, 7'h28, 7'h2C: return 16'h0002;
			7'h15: return 16'h0040;
			7'h1B: return 16'h0027;
			7'h1C: return 16'h0036;
			7'h1F, 7'h25: return 16'h0004;
			7'h21: return 16'h000A;
			7'h23: return 16'h0005;
			7'h27: return 16'h0016;
			7'h2D: return 16'h0007;
			7'h2F: return 16'h0020;
			7'h31: return 16'h003E;
			7'h34: return 16'h0001;
			default: return 16'h0000;
		endcase
	endfunction
	assign unprot = flashResetVid;
	assign drive = !flashCeN && !flashOeN;
	assign rdv = query ? cfiWord(flashAddr[6:0]) : 16'hA5C3;
	always @* if (drive) lastQ = rdv;
	assign dq = {(drive && flashByteN) ? rdv[15:8] : ~lastQ[15:8],
		drive ? rdv[7:0] : ~lastQ[7:0]};
	// Puts the device in identification mode
	task automatic set_ident;
		ident = 1'b1;
	endtask
	always @(negedge flashWeN or negedge flashCeN) begin
		if (!flashWeN && !flashCeN) cmdAddr = {flashAddr, flashAddrM1};
	end
	always @(posedge flashWeN or posedge flashCeN) begin
		if (flashOeN && (flashWeN ^ flashCeN) && $time >= PWR_NS) begin
			if (flashDqOut[7:0] == 8'h98 && !query && cmdAddr[21:1] == 21'h55
				&& (flashByteN || !cmdAddr[0])) query = 1'b1;
			if (flashDqOut[7:0] == 8'hF0) begin
				if (query) query = 1'b0;
				else ident = 1'b0;
			end
		end
	end
	always @(negedge flashOeN) begin
		if (query && flashByteN && flashAddr[20:7] != 14'h0) badAddr++;
	end
endmodule // fqu_flash_model
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the flash query host controller
// Assumes: Short power-up hold-off of 20 cycles
// Notes: Expected query words come from the bench's own table
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fqu_pkg::*;
	localparam int PWR = 20;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic opValid = 1'b0;
	fqu_op_e opCode = OP_READ;
	logic [IDX_W-1:0] opIndex = 7'h00;
	logic byteMode = 1'b0;
	logic tempUnprotect = 1'b0;
	logic opReady, opRefused, rdValid, inQuery, unprotectActive;
	logic flashCeN, flashWeN, flashOeN, flashByteN, flashAddrM1, flashDqOe, flashResetVid;
	logic [DATA_W-1:0] rdData, flashDqOut, flashDqIn, modelDq;
	logic [ADDR_W-1:0] flashAddr;
	int n_fail = 0;
	int checked = 0;
	always #4 ref_clk = ~ref_clk;
	assign flashDqIn = flashDqOe ? flashDqOut : modelDq;
	fqu_query_host #(.POWERUP_CYCLES(PWR)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
		.opValid(opValid), .opCode(opCode), .opIndex(opIndex), .byteMode(byteMode),
		.tempUnprotect(tempUnprotect), .opReady(opReady), .opRefused(opRefused),
		.rdValid(rdValid), .rdData(rdData), .inQuery(inQuery),
		.unprotectActive(unprotectActive), .flashCeN(flashCeN), .flashWeN(flashWeN),
		.flashOeN(flashOeN), .flashByteN(flashByteN), .flashAddr(flashAddr),
		.flashAddrM1(flashAddrM1), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe),
		.flashDqIn(flashDqIn), .flashResetVid(flashResetVid));
	fqu_flash_model u_flash (.flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN),
		.flashByteN(flashByteN), .flashAddr(flashAddr), .flashAddrM1(flashAddrM1),
		.flashDqOut(flashDqOut), .flashResetVid(flashResetVid), .dq(modelDq));
	// ---------------------------------------------
	// Shared tasks
	// ---------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic op(input fqu_op_e c, input logic [6:0] i, output logic [15:0] d,
		output logic rf);
		int k;
		d = 16'h0000;
		for (k = 0; k < 50 && opReady !== 1'b1; k++) @(negedge ref_clk);
		opCode = c;
		opIndex = i;
		opValid = 1'b1;
		@(negedge ref_clk);
		opValid = 1'b0;
		rf = opRefused;
		for (k = 0; k < 50; k++) begin
			@(negedge ref_clk);
			if (rdValid === 1'b1) d = rdData;
			if (opReady === 1'b1) break;
		end
		chk({15'h0, opReady}, 16'h0001, "ready");
	endtask
	function automatic logic [15:0] exp_word(input logic [6:0] i);
		case (i)
			7'h10: return 16'h0051;
			7'h11: return 16'h0052;
			7'h12: return 16'h0059;
			7'h13, 7'h28, 7'h2C: return 16'h0002;
			7'h15: return 16'h0040;
			7'h1B: return 16'h0027;
			7'h1C: return 16'h0036;
			7'h1F, 7'h25: return 16'h0004;
			7'h21: return 16'h000A;
			7'h23: return 16'h0005;
			7'h27: return 16'h0016;
			7'h2D: return 16'h0007;
			7'h2F: return 16'h0020;
			7'h31: return 16'h003E;
			7'h34: return 16'h0001;
			default: return 16'h0000;
		endcase
	endfunction
	task automatic close_out;
		$display("Counts: checked %0d, failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task automatic t_powerup;
		int k;
		repeat (PWR) begin
			@(negedge ref_clk);
			chk({13'h0, opReady, flashWeN, flashCeN}, 16'h0003, "holdoff");
		end
		for (k = 0; k < 5 && opReady !== 1'b1; k++) @(negedge ref_clk);
		chk({14'h0, inQuery, u_flash.query}, 16'h0000, "array read");
		$display("test powerup done");
	endtask
	task automatic t_word;
		logic [15:0] d;
		logic rf;
		op(OP_ENTER, 7'h00, d, rf);
		chk({14'h0, inQuery, u_flash.query}, 16'h0003, "enter");
		op(OP_ENTER, 7'h00, d, rf);
		chk({15'h0, rf}, 16'h0001, "enter twice");
		op(fqu_op_e'(2'h3), 7'h00, d, rf);
		chk({15'h0, rf}, 16'h0001, "bad code");
		for (int i = 16; i <= 60; i++) begin
			op(OP_READ, 7'(i), d, rf);
			chk(d, exp_word(7'(i)), "word");
		end
		op(OP_EXIT, 7'h00, d, rf);
		chk({14'h0, inQuery, u_flash.query}, 16'h0000, "exit");
		chk(16'(u_flash.badAddr), 16'h0000, "upper addr");
		$display("test word done");
	endtask
	task automatic t_byte;
		logic [15:0] d;
		logic rf;
		byteMode = 1'b1;
		op(OP_ENTER, 7'h00, d, rf);
		chk({15'h0, u_flash.query}, 16'h0001, "byte enter");
		for (int i = 16; i <= 52; i += 3) begin
			op(OP_READ, 7'(i), d, rf);
			chk(d, exp_word(7'(i)) & 16'h00FF, "byte");
		end
		op(OP_EXIT, 7'h00, d, rf);
		chk({15'h0, u_flash.query}, 16'h0000, "byte exit");
		byteMode = 1'b0;
		$display("test byte done");
	endtask
	task automatic t_ident;
		logic [15:0] d;
		logic rf;
		u_flash.set_ident();
		op(OP_ENTER, 7'h00, d, rf);
		chk({14'h0, u_flash.ident, u_flash.query}, 16'h0003, "ident enter");
		op(OP_READ, 7'h10, d, rf);
		chk(d, 16'h0051, "ident query");
		op(OP_EXIT, 7'h00, d, rf);
		chk({14'h0, u_flash.ident, u_flash.query}, 16'h0002, "ident back");
		op(OP_EXIT, 7'h00, d, rf);
		chk({14'h0, u_flash.ident, u_flash.query}, 16'h0000, "ident exit");
		$display("test ident done");
	endtask
	task automatic t_unprot;
		tempUnprotect = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk({14'h0, unprotectActive, u_flash.unprot}, 16'h0003, "vid on");
		tempUnprotect = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk({14'h0, unprotectActive, u_flash.unprot}, 16'h0000, "vid off");
		$display("test unprotect done");
	endtask
	initial begin
		repeat (4) @(negedge ref_clk);
		resetn = 1'b1;
		t_powerup();
		t_word();
		t_byte();
		t_ident();
		t_unprot();
		close_out();
	end
	initial begin
		#200000;
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out();
	end
endmodule // testbench
`default_nettype wire
